// ==== common/hss_pkg.sv ====
// Constants, types and state codes for the hot-swap start-up sequencer
// Behaviour
// - Address is base field plus strap field, or plus device field when both straps are open
// - Each strap decodes to four levels
// - Initialise once supply valid, then read configuration
// - Read configuration, then check switch
// - Switch shorts go to fault, else standby
// - Standby holds while disabled or off unless a restart is requested
// - Bad input voltage on leaving standby faults
// - Start-up needs enable and on; watchdog starts
// - Start-up limits switch current by profile
// - Low drain and high gate voltage: on
// - On fully enhances; overcurrent goes to regulation
// - On resets watchdog; restart or fault exits
// - Fault holds switch off, retries or latches
// - Restart waits ten seconds, then standby
package hss_pkg;

  localparam longint CLK_HZ = 200_000_000;
  localparam longint RESTART_WAIT_S = 10;
  localparam longint RESTART_WAIT_CYC = RESTART_WAIT_S * CLK_HZ;
  localparam longint WATCHDOG_US = 1000;
  localparam longint WATCHDOG_CYC = WATCHDOG_US * CLK_HZ / 1_000_000;
  localparam longint COOLDOWN_US = 1000;
  localparam longint COOLDOWN_CYC = COOLDOWN_US * CLK_HZ / 1_000_000;

  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] CFG_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] ISTAT_OFF = 8'h0c;
  localparam logic [7:0] IMASK_OFF = 8'h10;

  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam logic CTRL_ON_RST = 1'b1;
  localparam int CFG_BASE_LSB = 0;
  localparam int CFG_DEV_LSB = 4;
  localparam int CFG_RETRY_LSB = 8;
  localparam logic [31:0] CFG_RST = 32'h0000_0301;
  localparam logic [31:0] CFG_WMASK = 32'h0000_0ff7;
  localparam logic [1:0] STRAP_OPEN = 2'h3;

  localparam int EV_W = 4;
  localparam int EV_FAULT = 0;
  localparam int EV_ON = 1;
  localparam int EV_LATCH = 2;
  localparam int EV_WDOG = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic supply_ok;
    logic uv_ok;
    logic ov_ok;
    logic input_overvoltage_limit_ok;
    logic temp_ok;
    logic ds_short;
    logic gd_short;
    logic vds_low;
    logic vgs_high;
    logic oc_det;
    logic soa_viol;
    logic fault;
  } hss_sense_t;

  typedef enum logic [3:0] {
    ST_POR = 4'h0,
    ST_READ = 4'h1,
    ST_CHK = 4'h3,
    ST_STBY = 4'h2,
    ST_SOA = 4'h6,
    ST_ON = 4'h7,
    ST_IREG = 4'h5,
    ST_FAULT = 4'h4,
    ST_LATCH = 4'hc,
    ST_WAIT = 4'hf
  } hss_state_t;

  function automatic logic [3:0] hss_state_num(input hss_state_t s);
    logic [3:0] n;
    n = 4'h0;
    unique case (s)
      ST_POR: n = 4'h0;
      ST_READ: n = 4'h1;
      ST_CHK: n = 4'h2;
      ST_STBY: n = 4'h3;
      ST_SOA: n = 4'h4;
      ST_ON: n = 4'h5;
      ST_IREG: n = 4'h6;
      ST_FAULT: n = 4'h7;
      ST_LATCH: n = 4'h8;
      ST_WAIT: n = 4'ha;
      default: n = 4'hf;
    endcase
    return n;
  endfunction : hss_state_num

endpackage : hss_pkg

// ==== design/hss_strap_decode.sv ====
// Four-level strap pin decode from three threshold comparators
`timescale 1ns/10ps
module hss_strap_decode
(
  input wire logic [2:0] level_th,
  output logic [1:0] code
);

  // Comparators at 0.8, 1.6 and 2.4 V, thermometer coded
  assign code = level_th[2] ? 2'h3 :
                level_th[1] ? 2'h2 :
                level_th[0] ? 2'h1 : 2'h0;

endmodule : hss_strap_decode

// ==== design/hss_timer.sv ====
// One-shot down-counting timer with start and clear
`timescale 1ns/10ps
module hss_timer
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic clr,
  input wire logic [31:0] load_val,
  output logic done
);

  logic [31:0] cnt_q;
  logic arm_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= 32'h0000_0000;
      arm_q <= 1'b0;
    end
    else if (clr)
    begin
      cnt_q <= 32'h0000_0000;
      arm_q <= 1'b0;
    end
    else if (start)
    begin
      cnt_q <= load_val;
      arm_q <= 1'b1;
    end
    else if (cnt_q != 32'h0000_0000)
    begin
      cnt_q <= cnt_q - 32'h0000_0001;
    end
  end

  // Stays high until the next start or clear
  assign done = arm_q && (cnt_q == 32'h0000_0000);

endmodule : hss_timer

// ==== design/hss_startup_seq.sv ====
// Hot-swap start-up sequencer with AXI4-Lite registers and interrupt
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
module hss_startup_seq
  import hss_pkg::*;
#(
  parameter logic [31:0] WAIT_CYC = 32'(RESTART_WAIT_CYC),
  parameter logic [31:0] WDOG_CYC = 32'(WATCHDOG_CYC),
  parameter logic [31:0] COOL_CYC = 32'(COOLDOWN_CYC)
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic en_in,
  input wire hss_sense_t sense,
  input wire logic [2:0] upper_strap_pin,
  input wire logic [2:0] lower_strap_pin,
  output logic gate_full_on,
  output logic gate_regulate,
  output logic [6:0] bus_addr,
  output logic irq
);

  hss_state_t state_q, state_d;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_got_q, w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic on_q, restart_q, en_q;
  logic [31:0] cfg_q;
  logic [EV_W-1:0] istat_q, imask_q;
  logic [3:0] retry_q;
  logic [6:0] addr_q;
  logic gate_on_q, gate_reg_q, irq_q;

  // Bus decode
  logic aw_hs, w_hs, ar_hs, do_wr, b_done, r_done;
  logic wr_ctrl, wr_cfg, wr_istat, wr_imask, wr_hit, rd_hit;
  logic [31:0] wmask, rd_word;
  assign aw_hs = awvalid & awready_q;
  assign w_hs = wvalid & wready_q;
  assign ar_hs = arvalid & arready_q;
  assign do_wr = aw_got_q & w_got_q & ~bvalid_q;
  assign b_done = bvalid_q & bready;
  assign r_done = rvalid_q & rready;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                  {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wr_ctrl = do_wr & (awaddr_q == CTRL_OFF);
  assign wr_cfg = do_wr & (awaddr_q == CFG_OFF);
  assign wr_istat = do_wr & (awaddr_q == ISTAT_OFF);
  assign wr_imask = do_wr & (awaddr_q == IMASK_OFF);
  assign wr_hit = wr_ctrl | wr_cfg | wr_istat | wr_imask |
                  (awaddr_q == STATUS_OFF);
  assign rd_hit = (araddr == CTRL_OFF) | (araddr == CFG_OFF) |
                  (araddr == STATUS_OFF) | (araddr == ISTAT_OFF) |
                  (araddr == IMASK_OFF);
  assign rd_word =
    (araddr == CTRL_OFF) ? {31'h0, on_q} :
    (araddr == CFG_OFF) ? cfg_q :
    (araddr == STATUS_OFF) ? {16'h0, retry_q, 1'b0, addr_q,
                              hss_state_num(state_q)} :
    (araddr == ISTAT_OFF) ? {28'h0, istat_q} :
    (araddr == IMASK_OFF) ? {28'h0, imask_q} : 32'h0000_0000;

  // Write channel capture, either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      aw_got_q <= (aw_got_q | aw_hs) & ~do_wr;
      w_got_q <= (w_got_q | w_hs) & ~do_wr;
      awready_q <= ~((aw_got_q | aw_hs) & ~do_wr);
      wready_q <= ~((w_got_q | w_hs) & ~do_wr);
      if (aw_hs)
        awaddr_q <= awaddr;
      if (w_hs)
      begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (do_wr)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (b_done)
        bvalid_q <= 1'b0;
    end
  end

  // Read channel, answer one cycle after address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else
    begin
      if (ar_hs)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (r_done)
        rvalid_q <= 1'b0;
      arready_q <= ~(ar_hs | (rvalid_q & ~rready));
    end
  end

  // Strap decode and address choice
  logic [1:0] up_code, lo_code;
  logic [3:0] dev_sel;
  logic [6:0] addr_new;
  hss_strap_decode u_up_strap (
    .level_th(upper_strap_pin),
    .code(up_code)
  );
  hss_strap_decode u_lo_strap (
    .level_th(lower_strap_pin),
    .code(lo_code)
  );
  assign dev_sel = (up_code == STRAP_OPEN && lo_code == STRAP_OPEN) ?
                   cfg_q[CFG_DEV_LSB +: 4] : {up_code, lo_code};
  assign addr_new = {cfg_q[CFG_BASE_LSB +: 3], dev_sel};

  // Sequencer conditions
  logic run_ok, volt_ok, en_fall, regulate_req, retry_out;
  logic wdog_done, cool_done, wait_done;
  logic enter_soa, enter_on, enter_fault, enter_wait, enter_latch;
  assign run_ok = en_in & on_q;
  assign volt_ok = sense.uv_ok & sense.ov_ok & sense.input_overvoltage_limit_ok &
                   sense.temp_ok;
  assign en_fall = en_q & ~en_in;
  assign regulate_req = sense.oc_det | sense.soa_viol;
  assign retry_out = retry_q >= cfg_q[CFG_RETRY_LSB +: 4];
  assign enter_soa = (state_d == ST_SOA) && (state_q != ST_SOA);
  assign enter_on = (state_d == ST_ON) && (state_q != ST_ON);
  assign enter_fault = (state_d == ST_FAULT) && (state_q != ST_FAULT);
  assign enter_wait = (state_d == ST_WAIT) && (state_q != ST_WAIT);
  assign enter_latch = (state_d == ST_LATCH) && (state_q != ST_LATCH);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_POR:
        if (sense.supply_ok)
          state_d = ST_READ;
      ST_READ:
        state_d = ST_CHK;
      ST_CHK:
        state_d = (sense.ds_short | sense.gd_short) ?
                  ST_FAULT : ST_STBY;
      ST_STBY:
        if (restart_q)
          state_d = ST_WAIT;
        else if (run_ok)
          state_d = volt_ok ? ST_SOA : ST_FAULT;
      ST_SOA:
        if (sense.fault | wdog_done)
          state_d = ST_FAULT;
        else if (!run_ok)
          state_d = ST_STBY;
        else if (sense.vds_low & sense.vgs_high)
          state_d = ST_ON;
      ST_ON, ST_IREG:
        if (sense.fault)
          state_d = ST_FAULT;
        else if (restart_q)
          state_d = ST_WAIT;
        else if (!run_ok)
          state_d = ST_STBY;
        else
          state_d = regulate_req ? ST_IREG : ST_ON;
      ST_FAULT:
        if (cool_done && !sense.fault)
          state_d = retry_out ? ST_LATCH : ST_CHK;
      ST_LATCH:
        if (restart_q | en_fall)
          state_d = ST_CHK;
      ST_WAIT:
        if (wait_done)
          state_d = ST_STBY;
      default:
        state_d = ST_POR;
    endcase
  end

  hss_timer u_wdog (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(enter_soa),
    .clr(enter_on),
    .load_val(WDOG_CYC),
    .done(wdog_done)
  );
  hss_timer u_cool (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(enter_fault),
    .clr(1'b0),
    .load_val(COOL_CYC),
    .done(cool_done)
  );
  hss_timer u_wait (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(enter_wait),
    .clr(1'b0),
    .load_val(WAIT_CYC),
    .done(wait_done)
  );

  // Events: set wins over a same-cycle write-one clear
  logic [EV_W-1:0] ev, istat_d;
  assign ev[EV_FAULT] = enter_fault;
  assign ev[EV_ON] = enter_on;
  assign ev[EV_LATCH] = enter_latch;
  assign ev[EV_WDOG] = (state_q == ST_SOA) & wdog_done;
  assign istat_d = (istat_q & ~(wr_istat ? wdata_q[EV_W-1:0] &
                   wmask[EV_W-1:0] : {EV_W{1'b0}})) | ev;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_POR;
      on_q <= CTRL_ON_RST;
      restart_q <= 1'b0;
      en_q <= 1'b0;
      cfg_q <= CFG_RST;
      istat_q <= {EV_W{1'b0}};
      imask_q <= {EV_W{1'b0}};
      irq_q <= 1'b0;
      retry_q <= 4'h0;
      addr_q <= 7'h00;
      gate_on_q <= 1'b0;
      gate_reg_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      en_q <= en_in;
      restart_q <= wr_ctrl & wstrb_q[0] & wdata_q[CTRL_RESTART_BIT];
      if (wr_ctrl && wstrb_q[0])
        on_q <= wdata_q[CTRL_ON_BIT];
      if (wr_cfg)
        cfg_q <= (cfg_q & ~(wmask & CFG_WMASK)) |
                 (wdata_q & wmask & CFG_WMASK);
      if (wr_imask)
        imask_q <= (imask_q & ~wmask[EV_W-1:0]) |
                   (wdata_q[EV_W-1:0] & wmask[EV_W-1:0]);
      istat_q <= istat_d;
      irq_q <= |(istat_d & imask_q);
      // Address frozen until the next power-on pass
      if (state_q == ST_READ)
        addr_q <= addr_new;
      if (state_q == ST_LATCH && state_d == ST_CHK)
        retry_q <= 4'h0;
      else if (state_q == ST_FAULT && state_d == ST_CHK)
        retry_q <= retry_q + 4'h1;
      gate_on_q <= (state_d == ST_ON);
      // Analog loop follows the profile while this is high
      gate_reg_q <= (state_d == ST_SOA) || (state_d == ST_IREG);
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign gate_full_on = gate_on_q;
  assign gate_regulate = gate_reg_q;
  assign bus_addr = addr_q;
  assign irq = irq_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_POR_ADV: assert property (
    state_q == ST_POR && sense.supply_ok |=> state_q == ST_READ)
    else $error("init did not advance");
  AST_READ_ADV: assert property (
    state_q == ST_READ |=> state_q == ST_CHK ##1 state_q != ST_CHK)
    else $error("config read did not advance to check");
  AST_CHK_FAULT: assert property (
    state_q == ST_CHK && (sense.ds_short || sense.gd_short)
    |=> state_q == ST_FAULT)
    else $error("short not sent to fault");
  AST_STBY_HOLD: assert property (
    state_q == ST_STBY && !run_ok && !restart_q |=> state_q == ST_STBY)
    else $error("standby left while disabled");
  AST_STBY_VOLT: assert property (
    state_q == ST_STBY && run_ok && !restart_q && !volt_ok
    |=> state_q == ST_FAULT)
    else $error("bad input voltage not faulted");
  AST_SOA_ENTRY: assert property (
    state_q == ST_SOA && $past(state_q) != ST_SOA
    |-> $past(state_q) == ST_STBY && $past(run_ok) && !wdog_done)
    else $error("start-up entered without enable and on");
  AST_SOA_GATE: assert property (
    gate_regulate == (state_q == ST_SOA || state_q == ST_IREG))
    else $error("regulation output out of step");
  AST_SOA_DONE: assert property (
    state_q == ST_SOA && run_ok && !sense.fault && !wdog_done &&
    sense.vds_low && sense.vgs_high |=> state_q == ST_ON ##1 !wdog_done)
    else $error("start-up did not complete");
  AST_ON_IREG: assert property (
    state_q == ST_ON && run_ok && !sense.fault && !restart_q &&
    regulate_req |=> state_q == ST_IREG && !gate_full_on)
    else $error("overcurrent not regulated");
  AST_ON_WAIT: assert property (
    state_q == ST_ON && !sense.fault && restart_q
    |=> state_q == ST_WAIT)
    else $error("restart ignored in on");
  AST_FAULT_OFF: assert property (
    state_q == ST_FAULT && (sense.fault || !cool_done)
    |-> !gate_full_on && !gate_regulate ##1 state_q == ST_FAULT)
    else $error("fault state drove switch or left early");
  AST_WAIT_EXIT: assert property (
    state_q == ST_WAIT && wait_done |=> state_q == ST_STBY)
    else $error("restart wait did not end in standby");
  AST_ADDR_LOAD: assert property (
    state_q == ST_READ |=> bus_addr == $past(addr_new))
    else $error("bus address not loaded from straps");
  AST_ADDR_HOLD: assert property (
    state_q != ST_READ |=> $stable(bus_addr))
    else $error("bus address changed outside config read");

  COV_ON: cover property (state_q == ST_SOA ##1 state_q == ST_ON);
  COV_IREG: cover property (state_q == ST_IREG);
  COV_LATCH: cover property (state_q == ST_LATCH);
  COV_WAIT: cover property (state_q == ST_WAIT ##1 state_q == ST_STBY);

endmodule : hss_startup_seq

// ==== bench/hss_far_model.sv ====
// Pass switch and analog sense model on the far side of the sequencer
`timescale 1ns/10ps
module hss_far_model
  import hss_pkg::*;
(
  input wire logic aclk,
  input wire logic gate_regulate,
  input wire logic gate_full_on,
  input wire logic supply_in,
  input wire logic short_in,
  input wire logic bad_v_in,
  input wire logic oc_in,
  input wire logic soa_in,
  input wire logic fault_in,
  input wire logic [7:0] ramp_cyc,
  output hss_sense_t sense
);
  logic [7:0] ramp_q;
  logic [7:0] ramp_d;
  logic charged;

  // Output charges only while the gate is driven; a ramp of 255 never ends
  assign ramp_d = (!(gate_regulate || gate_full_on)) ? 8'h00 :
                  (ramp_q == 8'hff) ? ramp_q : ramp_q + 8'h01;
  assign charged = (ramp_q >= ramp_cyc) && (ramp_cyc != 8'hff);

  always_ff @(posedge aclk)
    ramp_q <= ramp_d;

  always_comb
  begin
    sense = '0;
    sense.supply_ok = supply_in;
    sense.uv_ok = !bad_v_in;
    sense.ov_ok = 1'b1;
    sense.input_overvoltage_limit_ok = !bad_v_in;
    sense.temp_ok = 1'b1;
    sense.ds_short = short_in;
    sense.gd_short = short_in;
    sense.vds_low = charged;
    sense.vgs_high = charged;
    sense.oc_det = oc_in;
    sense.soa_viol = soa_in;
    sense.fault = fault_in;
  end
endmodule : hss_far_model

// ==== bench/tb_hot_swap_startup_sequencer.sv ====
// Self-checking bench for the hot-swap start-up sequencer
`timescale 1ns/10ps
module tb_hot_swap_startup_sequencer
  import hss_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic en = 1'b0;
  logic sup = 1'b0;
  logic sht = 1'b0;
  logic badv = 1'b0;
  logic oc = 1'b0;
  logic soa = 1'b0;
  logic flt = 1'b0;
  logic [7:0] ramp = 8'h14;
  logic [2:0] up = 3'h0;
  logic [2:0] lo = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, irq, gfo, greg;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [6:0] bus_addr;
  hss_sense_t sense;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;

  always #2.5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  // Short timer counts keep the run brief
  hss_startup_seq #(.WAIT_CYC(32'd20), .WDOG_CYC(32'd50), .COOL_CYC(32'd10))
  hss_startup_seq_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .en_in(en), .sense, .upper_strap_pin(up), .lower_strap_pin(lo),
    .gate_full_on(gfo), .gate_regulate(greg), .bus_addr, .irq);

  hss_far_model hss_far_model_inst (.aclk, .gate_regulate(greg),
    .gate_full_on(gfo), .supply_in(sup), .short_in(sht), .bad_v_in(badv),
    .oc_in(oc), .soa_in(soa), .fault_in(flt), .ramp_cyc(ramp), .sense);

  task automatic final_report;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic hang;
    err_count++;
    final_report();
  endtask : hang

  task automatic wr(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : wr

  task automatic rd(logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : rd

  task automatic wait_st(logic [3:0] n);
    logic [31:0] d;
    logic [1:0] r;
    for (int k = 0; k < 300; k++)
    begin
      rd(STATUS_OFF, d, r);
      if (d[3:0] === n) return;
    end
    hang();
  endtask : wait_st

  task automatic rst;
    aresetn <= 1'b0;
    sup <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : rst

  // Strap level code to comparator thermometer
  function automatic logic [2:0] th(logic [1:0] c);
    return {c == 2'h3, c[1], c != 2'h0};
  endfunction : th

  function automatic logic [6:0] exp_addr(logic [2:0] b, logic [3:0] d,
                                          logic [1:0] u, logic [1:0] l);
    return (u == 2'h3 && l == 2'h3) ? {b, d} : {b, u, l};
  endfunction : exp_addr

  initial
  begin
    logic [31:0] d;
    logic [1:0] r, u, l;
    logic [2:0] b;
    logic [3:0] dv;
    int t0;
    void'($urandom(99494));
    rst();
    // Neither write may touch a register
    wr(8'h14, 32'hffff_ffff, r);
    chk("unmapped_wr_resp", r, RESP_SLVERR);
    wr(STATUS_OFF, 32'hffff_ffff, r);
    chk("status_wr_resp", r, RESP_OKAY);
    rd(CFG_OFF, d, r);
    chk("cfg", d, CFG_RST);
    rd(CTRL_OFF, d, r);
    chk("ctrl", d, 32'h1);
    rd(8'h14, d, r);
    chk("unmapped_resp", r, RESP_SLVERR);
    chk("unmapped_data", d, 32'h0);
    rd(STATUS_OFF, d, r);
    chk("por_status", d, 32'h0);
    // Corners first: all grounded, then both open
    for (int i = 0; i < 6; i++)
    begin
      u = (i < 2) ? {2{i[0]}} : 2'($urandom);
      l = (i < 2) ? {2{i[0]}} : 2'($urandom);
      b = 3'($urandom);
      dv = 4'($urandom);
      rst();
      up <= th(u);
      lo <= th(l);
      wr(CFG_OFF, {20'h0, 4'h3, dv, 1'b0, b}, r);
      chk("cfg_resp", r, RESP_OKAY);
      sup <= 1'b1;
      wait_st(4'h3);
      chk("addr", bus_addr, exp_addr(b, dv, u, l));
      up <= th(~u);
      lo <= th(~l);
      repeat (5) @(posedge aclk);
      rd(STATUS_OFF, d, r);
      chk("addr_held", d[10:4], exp_addr(b, dv, u, l));
      chk("stby", d[3:0], 4'h3);
    end
    wr(IMASK_OFF, 32'h3, r);
    en <= 1'b1;
    wait_st(4'h4);
    chk("soa_gate", {gfo, greg}, 2'b01);
    wait_st(4'h5);
    chk("on_gate", {gfo, greg}, 2'b10);
    rd(ISTAT_OFF, d, r);
    chk("ev_on", d[3:0], 4'h2);
    chk("irq_on", irq, 1'b1);
    wr(ISTAT_OFF, 32'h2, r);
    chk("irq_clr", irq, 1'b0);
    // Overcurrent, then a profile violation
    for (int k = 0; k < 2; k++)
    begin
      oc <= (k == 0);
      soa <= (k == 1);
      wait_st(4'h6);
      chk("ireg_gate", {gfo, greg}, 2'b01);
      oc <= 1'b0;
      soa <= 1'b0;
      wait_st(4'h5);
    end
    // A fault held past cool-down keeps the switch off
    flt <= 1'b1;
    wait_st(4'h7);
    repeat (20) @(posedge aclk);
    rd(STATUS_OFF, d, r);
    chk("fault_hold", d[3:0], 4'h7);
    chk("fault_hold_gate", {gfo, greg}, 2'b00);
    flt <= 1'b0;
    wait_st(4'h5);
    wr(ISTAT_OFF, 32'hf, r);
    chk("istat_wr_resp", r, RESP_OKAY);
    en <= 1'b0;
    wait_st(4'h3);
    chk("off_gate", {gfo, greg}, 2'b00);
    wr(CTRL_OFF, 32'h0, r);
    en <= 1'b1;
    repeat (20) @(posedge aclk);
    rd(STATUS_OFF, d, r);
    chk("on_bit_hold", d[3:0], 4'h3);
    badv <= 1'b1;
    wr(CTRL_OFF, 32'h1, r);
    wait_st(4'h7);
    chk("irq_fault", irq, 1'b1);
    chk("fault_gate", {gfo, greg}, 2'b00);
    en <= 1'b0;
    badv <= 1'b0;
    wr(ISTAT_OFF, 32'hf, r);
    wait_st(4'h3);
    // A ramp that never completes lets the turn-on watchdog run out
    ramp <= 8'hff;
    en <= 1'b1;
    wait_st(4'h4);
    wait_st(4'h7);
    rd(ISTAT_OFF, d, r);
    chk("wdog", d[3], 1'b1);
    en <= 1'b0;
    rst();
    sht <= 1'b1;
    sup <= 1'b1;
    wait_st(4'h8);
    rd(STATUS_OFF, d, r);
    chk("retries", d[15:12], 4'h3);
    sht <= 1'b0;
    wr(CTRL_OFF, 32'h3, r);
    wait_st(4'h3);
    wr(CTRL_OFF, 32'h3, r);
    wait_st(4'ha);
    t0 = cyc;
    chk("wait_gate", {gfo, greg}, 2'b00);
    wait_st(4'h3);
    chk("wait_len", (cyc - t0) inside {[14:30]}, 1'b1);
    final_report();
  end
endmodule : tb_hot_swap_startup_sequencer
